/* hw/cerb_consts.svh */
`ifndef CERB_CONSTS_SVH
`define CERB_CONSTS_SVH
`define CERB_OFF_CFG 12'h000
`define CERB_OFF_LOAD 12'h004
`define CERB_OFF_STAT 12'h008
`define CERB_OFF_DOUT 12'h00c
`define CERB_CFG_W 13
`define CERB_CFG_RST 13'h0000
`define CERB_F_SHAPE 1:0
`define CERB_F_MODE 3:2
`define CERB_F_RDIN 4
`define CERB_F_RDOUT 5
`define CERB_F_RADDR 6
`define CERB_F_WESRC 7
`define CERB_F_ICLK 9:8
`define CERB_F_OCLK 11:10
`define CERB_F_LOCK 12
`define CERB_LD_DATA 7:0
`define CERB_LD_ROW 15:8
`define CERB_LD_BROW 18:16
`define CERB_LD_BCOL 21:19
`define CERB_ST_LOCK 0
`define CERB_ST_EMPTY 1
`define CERB_ST_FULL 2
`define CERB_ST_CNT 4
`define CERB_RAM_WORDS 256
`endif

/* hw/cerb_pkg.sv */
package cerb_pkg;
  typedef enum logic [1:0] {
    CERB_SHAPE_256X8,
    CERB_SHAPE_512X4,
    CERB_SHAPE_1024X2,
    CERB_SHAPE_2048X1
  } cerb_shape_t;
  typedef enum logic [1:0] {
    CERB_MODE_SPRAM,
    CERB_MODE_ROM,
    CERB_MODE_DPRAM,
    CERB_MODE_FIFO
  } cerb_mode_t;
  typedef enum logic [1:0] {
    CERB_SRC_GLB,
    CERB_SRC_PIN,
    CERB_SRC_LOC,
    CERB_SRC_OFF
  } cerb_src_t;
endpackage

/* hw/cerb_ram_if.sv */
`timescale 1ns/100ps
interface cerb_ram_if;
  logic [7:0] wrow;
  logic [7:0] wdata;
  logic [7:0] wmask;
  logic we;
  logic [7:0] rrow;
  logic [7:0] rdata;
  modport ctl(output wrow, output wdata, output wmask, output we, output rrow, input rdata);
  modport mem(input wrow, input wdata, input wmask, input we, input rrow, output rdata);
endinterface

/* hw/cerb_ram.sv */
`timescale 1ns/100ps
`include "cerb_consts.svh"
module cerb_ram (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  cerb_ram_if.mem port
);
  logic [7:0] mem_q [`CERB_RAM_WORDS];
  logic [7:0] rdata_ff;

  // Bit-masked write keeps the other lanes of the byte
  always_ff @(posedge pclk) begin
    if (ce && port.we) begin
      mem_q[port.wrow] <= (mem_q[port.wrow] & ~port.wmask) | (port.wdata & port.wmask);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_ff <= 8'h00;
    end else if (ce) begin
      rdata_ff <= mem_q[port.rrow];
    end
  end

  assign port.rdata = rdata_ff;
endmodule

/* hw/cerb_clksel.sv */
`timescale 1ns/100ps
module cerb_clksel
  import cerb_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire cerb_src_t sel,
  input wire logic glb,
  input wire logic pin,
  input wire logic loc,
  output logic stb
);
  logic pin_s1_ff;
  logic pin_s2_ff;
  logic lvl_ff;
  logic stb_ff;
  wire logic lvl;

  // Source choice for this side's clock
  assign lvl = (sel == CERB_SRC_GLB) ? glb :
               (sel == CERB_SRC_PIN) ? pin_s2_ff :
               (sel == CERB_SRC_LOC) ? loc : 1'b0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_ff <= 1'b0;
      pin_s2_ff <= 1'b0;
      lvl_ff <= 1'b0;
      stb_ff <= 1'b0;
    end else if (ce) begin
      pin_s1_ff <= pin;
      pin_s2_ff <= pin_s1_ff;
      lvl_ff <= lvl;
      stb_ff <= lvl & ~lvl_ff;
    end
  end

  assign stb = stb_ff;
endmodule

/* hw/cerb_top.sv */
`timescale 1ns/100ps
`include "cerb_consts.svh"
////////////////////////////////////////////////////////////////////////////////
module cerb_top
  import cerb_pkg::*;
#(
  parameter int ROWS = 1,
  parameter int COLS = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic glb_we,
  input wire logic glb_clk,
  input wire logic pin_in_clk,
  input wire logic pin_out_clk,
  input wire logic loc_in_clk,
  input wire logic loc_out_clk,
  input wire logic [10+$clog2(ROWS):0] usr_addr,
  input wire logic [10+$clog2(ROWS):0] usr_raddr,
  input wire logic [8*COLS-1:0] usr_din,
  input wire logic usr_we,
  input wire logic usr_re,
  output logic [8*COLS-1:0] usr_dout,
  output logic usr_empty,
  output logic usr_full
);
  localparam int BW = (ROWS > 1) ? $clog2(ROWS) : 1;
  localparam int AW = 11 + $clog2(ROWS);
  localparam int CW = AW + 1;
  localparam int DW = 8 * COLS;
  if (!(ROWS inside {1, 2, 4, 8}) || COLS < 1 || COLS > 4) begin : g_param_check
    $error("cerb_top: ROWS must be 1, 2, 4 or 8 and COLS 1 to 4");
  end

////////////////////////////////////////////////////////////////////////////////
  // Address to byte row of a block
  function automatic logic [7:0] row_of(input logic [AW-1:0] a, input logic [1:0] s);
    row_of = 8'(a >> s);
  endfunction

  // Bit offset of a word inside its byte
  function automatic logic [2:0] off_of(input logic [AW-1:0] a, input logic [1:0] s);
    logic [2:0] sub;
    sub = 3'(a) & 3'((4'h1 << s) - 4'h1);
    off_of = 3'(sub << (2'd3 - s));
  endfunction

  // Mask of the word width for a shape
  function automatic logic [7:0] lane_mask(input logic [1:0] s);
    lane_mask = 8'((9'h001 << (4'd8 >> s)) - 9'h001);
  endfunction

  // Which stacked block an address falls in
  function automatic logic [AW-1:0] blk_of(input logic [AW-1:0] a, input logic [1:0] s);
    blk_of = a >> (4'd8 + 4'(s));
  endfunction

  function automatic logic [AW-1:0] wrap_inc(input logic [AW-1:0] p,
                                             input logic [CW-1:0] depth);
    wrap_inc = (CW'(p) == depth - CW'(1)) ? '0 : p + AW'(1);
  endfunction

////////////////////////////////////////////////////////////////////////////////
  logic [`CERB_CFG_W-1:0] cfg_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] prdata_ff;
  logic [AW-1:0] addr_q_ff;
  logic we_q_ff;
  logic [DW-1:0] din_q_ff;
  logic [AW-1:0] raddr_q_ff;
  logic [AW-1:0] wptr_ff;
  logic [AW-1:0] rptr_ff;
  logic [CW-1:0] cnt_ff;
  logic full_ff;
  logic empty_ff;
  logic [2:0] rd_off_ff;
  logic [AW-1:0] rd_blk_ff;
  logic rd_ok_ff;
  logic [DW-1:0] dout_ff;
  wire logic [1:0] shp;
  wire cerb_mode_t mode;
  wire logic lock;
  wire logic is_rom;
  wire logic is_dp;
  wire logic is_fifo;
  wire logic [7:0] lmask;
  wire logic in_stb;
  wire logic out_stb;
  assign shp = cfg_ff[`CERB_F_SHAPE];
  assign mode = cerb_mode_t'(cfg_ff[`CERB_F_MODE]);
  assign lock = cfg_ff[`CERB_F_LOCK];
  assign is_rom = (mode == CERB_MODE_ROM);
  assign is_dp = (mode == CERB_MODE_DPRAM);
  assign is_fifo = (mode == CERB_MODE_FIFO);
  assign lmask = lane_mask(shp);
////////////////////////////////////////////////////////////////////////////////
  // Clock sources, one per side
  cerb_clksel u_in_clk (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .sel(cerb_src_t'(cfg_ff[`CERB_F_ICLK])),
    .glb(glb_clk),
    .pin(pin_in_clk),
    .loc(loc_in_clk),
    .stb(in_stb)
  );
  cerb_clksel u_out_clk (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .sel(cerb_src_t'(cfg_ff[`CERB_F_OCLK])),
    .glb(glb_clk),
    .pin(pin_out_clk),
    .loc(loc_out_clk),
    .stb(out_stb)
  );

////////////////////////////////////////////////////////////////////////////////
  // APB decode
  logic hit_cfg;
  logic hit_load;
  logic hit_stat;
  logic hit_dout;
  logic hit_none;
  always_comb begin
    hit_cfg = 1'b0;
    hit_load = 1'b0;
    hit_stat = 1'b0;
    hit_dout = 1'b0;
    hit_none = 1'b0;
    if (paddr == `CERB_OFF_CFG) begin
      hit_cfg = 1'b1;
    end else if (paddr == `CERB_OFF_LOAD) begin
      hit_load = 1'b1;
    end else if (paddr == `CERB_OFF_STAT) begin
      hit_stat = 1'b1;
    end else if (paddr == `CERB_OFF_DOUT) begin
      hit_dout = 1'b1;
    end else begin
      hit_none = 1'b1;
    end
  end

  wire logic acc_first;
  wire logic wr_done;
  wire logic cfg_wr;
  wire logic load_hit;
  wire logic bad_acc;
  wire logic [31:0] stat_word;
  wire logic [31:0] rd_mux;
  assign acc_first = psel & penable & ~pready_ff;
  assign wr_done = psel & penable & pready_ff & pwrite;
  assign cfg_wr = wr_done & hit_cfg & ~lock;
  assign load_hit = wr_done & hit_load & ~lock;
  assign bad_acc = hit_none | (pwrite & (hit_cfg | hit_load) & lock);
  assign stat_word = (32'(cnt_ff) << `CERB_ST_CNT) |
                     (32'(full_ff) << `CERB_ST_FULL) |
                     (32'(empty_ff) << `CERB_ST_EMPTY) |
                     (32'(lock) << `CERB_ST_LOCK);
  assign rd_mux = hit_cfg ? 32'(cfg_ff) :
                  hit_stat ? stat_word :
                  hit_dout ? 32'(dout_ff) : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else if (ce) begin
      pready_ff <= acc_first;
      pslverr_ff <= acc_first & bad_acc;
      if (acc_first && !pwrite) begin
        prdata_ff <= rd_mux;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_ff <= `CERB_CFG_RST;
    end else if (ce && cfg_wr) begin
      cfg_ff <= pwdata[`CERB_CFG_W-1:0];
    end
  end

////////////////////////////////////////////////////////////////////////////////
  // Input side
  wire logic we_sel;
  wire logic [AW-1:0] eff_addr;
  wire logic eff_we;
  wire logic [DW-1:0] eff_din;
  assign we_sel = cfg_ff[`CERB_F_WESRC] ? glb_we : usr_we;
  assign eff_addr = cfg_ff[`CERB_F_RADDR] ? addr_q_ff : usr_addr;
  assign eff_we = cfg_ff[`CERB_F_RADDR] ? we_q_ff : we_sel;
  assign eff_din = cfg_ff[`CERB_F_RDIN] ? din_q_ff : usr_din;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_q_ff <= '0;
      we_q_ff <= 1'b0;
      din_q_ff <= '0;
    end else if (ce && in_stb) begin
      addr_q_ff <= usr_addr;
      we_q_ff <= we_sel;
      din_q_ff <= usr_din;
    end
  end

  wire logic [CW-1:0] fifo_depth;
  wire logic [AW-1:0] waddr;
  wire logic [7:0] wr_row;
  wire logic [2:0] wr_off;
  wire logic [7:0] wr_mask;
  wire logic [AW-1:0] wr_blk;
  wire logic wr_go;
  wire logic push;
  wire logic pop;
  assign fifo_depth = CW'(ROWS) << (4'd8 + 4'(shp));
  assign waddr = is_fifo ? wptr_ff : eff_addr;
  assign wr_row = row_of(waddr, shp);
  assign wr_off = off_of(waddr, shp);
  assign wr_mask = 8'(lmask << wr_off);
  assign wr_blk = blk_of(waddr, shp);
  // Self-timed write strobe; ROM and full FIFO refuse it
  assign wr_go = in_stb & eff_we & ~is_rom & ~load_hit &
                 ~(is_fifo & full_ff) & (wr_blk < AW'(ROWS));
  assign push = wr_go & is_fifo;
  assign pop = out_stb & usr_re & ~empty_ff & is_fifo;

////////////////////////////////////////////////////////////////////////////////
  // Output side address
  wire logic [AW-1:0] rd_src;
  wire logic [AW-1:0] rd_addr;
  wire logic [7:0] rd_row;
  assign rd_src = cfg_ff[`CERB_F_RADDR] ? raddr_q_ff : usr_raddr;
  assign rd_addr = is_fifo ? rptr_ff : is_dp ? rd_src : eff_addr;
  assign rd_row = row_of(rd_addr, shp);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      raddr_q_ff <= '0;
      rd_off_ff <= 3'h0;
      rd_blk_ff <= '0;
      rd_ok_ff <= 1'b0;
    end else if (ce) begin
      if (out_stb) begin
        raddr_q_ff <= usr_raddr;
      end
      rd_off_ff <= off_of(rd_addr, shp);
      rd_blk_ff <= blk_of(rd_addr, shp);
      rd_ok_ff <= (blk_of(rd_addr, shp) < AW'(ROWS));
    end
  end

////////////////////////////////////////////////////////////////////////////////
  // Storage array, ROWS deep by COLS wide
  logic [7:0] rblk [ROWS][COLS];
  logic [7:0] col_wdata [COLS];
  wire logic [DW-1:0] rd_word;
  wire logic [BW-1:0] rd_idx;
  assign rd_idx = BW'(rd_blk_ff);
  cerb_ram_if rif [ROWS*COLS] ();
  genvar gr;
  genvar gc;
  for (gc = 0; gc < COLS; gc++) begin : g_lane
    assign col_wdata[gc] = 8'((eff_din[gc*8 +: 8] & lmask) << wr_off);
    assign rd_word[gc*8 +: 8] = rd_ok_ff ?
                                8'((rblk[rd_idx][gc] >> rd_off_ff) & lmask) : 8'h00;
  end

  for (gr = 0; gr < ROWS; gr++) begin : g_row
    for (gc = 0; gc < COLS; gc++) begin : g_col
      localparam int IX = gr * COLS + gc;
      assign rif[IX].we = load_hit ?
                          (int'(pwdata[`CERB_LD_BROW]) == gr &&
                           int'(pwdata[`CERB_LD_BCOL]) == gc) :
                          (wr_go && wr_blk == AW'(gr));
      assign rif[IX].wrow = load_hit ? pwdata[`CERB_LD_ROW] : wr_row;
      assign rif[IX].wdata = load_hit ? pwdata[`CERB_LD_DATA] : col_wdata[gc];
      assign rif[IX].wmask = load_hit ? 8'hff : wr_mask;
      assign rif[IX].rrow = rd_row;
      assign rblk[gr][gc] = rif[IX].rdata;
      cerb_ram u_ram (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .port(rif[IX])
      );
    end
  end

////////////////////////////////////////////////////////////////////////////////
  // FIFO pointers and flags
  wire logic [CW-1:0] nxt_cnt;
  assign nxt_cnt = cnt_ff + CW'(push) - CW'(pop);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wptr_ff <= '0;
      rptr_ff <= '0;
      cnt_ff <= '0;
      full_ff <= 1'b0;
      empty_ff <= 1'b1;
    end else if (ce) begin
      if (cfg_wr) begin
        wptr_ff <= '0;
        rptr_ff <= '0;
        cnt_ff <= '0;
        full_ff <= 1'b0;
        empty_ff <= 1'b1;
      end else begin
        if (push) begin
          wptr_ff <= wrap_inc(wptr_ff, fifo_depth);
        end
        if (pop) begin
          rptr_ff <= wrap_inc(rptr_ff, fifo_depth);
        end
        cnt_ff <= nxt_cnt;
        full_ff <= (nxt_cnt == fifo_depth);
        empty_ff <= (nxt_cnt == '0);
      end
    end
  end

////////////////////////////////////////////////////////////////////////////////
  // Read data out
  wire logic dout_upd;
  assign dout_upd = is_fifo ? pop : (cfg_ff[`CERB_F_RDOUT] ? out_stb : 1'b1);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dout_ff <= '0;
    end else if (ce && dout_upd) begin
      dout_ff <= rd_word;
    end
  end

  assign usr_dout = dout_ff;
  assign usr_empty = empty_ff;
  assign usr_full = full_ff;
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
endmodule

/* verif/cerb_top_assertions.sv */
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
module cerb_top_assertions #(
  parameter int COLS = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [8*COLS-1:0] usr_dout,
  input wire logic usr_empty,
  input wire logic usr_full
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Access phase waiting for its answer
  wire acc = psel && penable && !pready && ce;
  wire bad = !(paddr inside {12'h000, 12'h004, 12'h008, 12'h00c});
  AST_RDY_ANSWER: assert property (acc |=> pready) else $error("no answer");
  AST_RDY_PULSE: assert property (pready && ce |=> !pready) else $error("ready long");
  AST_RDY_CAUSE: assert property (pready |-> $past(psel && penable)) else $error("ready");
  AST_ERR_MAP: assert property (acc && bad |=> pslverr) else $error("no error");
  AST_READ_OK: assert property (acc && !pwrite && !bad |=> !pslverr) else $error("err");
  AST_ERR_RDY: assert property (pslverr |-> pready) else $error("lone error");
  AST_RD_HOLD: assert property ($changed(prdata) |-> $past(psel && penable && !pwrite))
    else $error("read data moved");
  AST_BAD_ZERO: assert property (acc && !pwrite && bad |=> prdata == 32'h0)
    else $error("unmapped data");
  AST_FLAGS: assert property (!(usr_empty && usr_full)) else $error("empty and full");
  AST_RST_OUT: assert property ($past(presetn) == 1'b0 |-> usr_empty && !usr_full
    && usr_dout == '0 && !pready) else $error("reset values");
  cover property (acc && pwrite);
  cover property (pready && pslverr);
  cover property (!usr_empty);
endmodule
////////////////////////////////////////////////////////////////////////////////
bind cerb_top cerb_top_assertions #(.COLS(COLS)) chk_u (.pclk(pclk), .presetn(presetn),
  .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .usr_dout(usr_dout),
  .usr_empty(usr_empty), .usr_full(usr_full));

/* verif/cerb_user_model.sv */
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// User logic side: makes local clock edges for the block
module cerb_user_model (
  input wire logic pclk,
  output logic loc_in_clk,
  output logic loc_out_clk
);
  initial begin
    loc_in_clk = 1'b0;
    loc_out_clk = 1'b0;
  end
  // One rising edge, then low until the strobe has acted
  task automatic edge_in();
    @(posedge pclk);
    loc_in_clk <= 1'b1;
    @(posedge pclk);
    loc_in_clk <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask
  task automatic edge_out();
    @(posedge pclk);
    loc_out_clk <= 1'b1;
    @(posedge pclk);
    loc_out_clk <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask
endmodule

/* verif/test_cerb_top.sv */
`timescale 1ns/100ps
`include "cerb_consts.svh"
////////////////////////////////////////////////////////////////////////////////
module test_cerb_top;
  import cerb_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic glb_we = 1'b0;
  logic ce = 1'b1;
  logic pin_in_clk = 1'b0;
  logic loc_in_clk;
  logic loc_out_clk;
  logic [10:0] usr_addr = 11'h000;
  logic [10:0] usr_raddr = 11'h000;
  logic [7:0] usr_din = 8'h00;
  logic usr_we = 1'b0;
  logic usr_re = 1'b0;
  logic [7:0] usr_dout;
  logic usr_empty;
  logic usr_full;
  logic [31:0] rdat;
  logic rerr;
  int n_fail = 0;
  int comparisons = 0;
  always #10 pclk = ~pclk;
  cerb_top #(.ROWS(1), .COLS(1)) dut_u (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .glb_we(glb_we),
    .glb_clk(1'b0), .pin_in_clk(pin_in_clk), .pin_out_clk(1'b0), .loc_in_clk(loc_in_clk),
    .loc_out_clk(loc_out_clk), .usr_addr(usr_addr), .usr_raddr(usr_raddr),
    .usr_din(usr_din), .usr_we(usr_we), .usr_re(usr_re), .usr_dout(usr_dout),
    .usr_empty(usr_empty), .usr_full(usr_full));
  cerb_user_model p_u (.pclk(pclk), .loc_in_clk(loc_in_clk), .loc_out_clk(loc_out_clk));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic ee);
    apb(1'b0, a, 32'h0);
    chk(rdat, e);
    chk({31'h0, rerr}, {31'h0, ee});
  endtask
  task automatic uwr(input logic [10:0] a, input logic [7:0] d);
    @(posedge pclk);
    usr_addr <= a;
    usr_din <= d;
    usr_we <= 1'b1;
    p_u.edge_in();
    usr_we <= 1'b0;
  endtask
  // Write request with one pulse on the input clock pin, clock enable as given
  task automatic pin_wr(input logic [10:0] a, input logic [7:0] d, input logic c);
    @(posedge pclk);
    ce <= c;
    usr_addr <= a;
    usr_din <= d;
    usr_we <= 1'b1;
    pin_in_clk <= 1'b1;
    repeat (3) @(posedge pclk);
    pin_in_clk <= 1'b0;
    repeat (4) @(posedge pclk);
    ce <= 1'b1;
    usr_we <= 1'b0;
  endtask
  task automatic ucheck(input logic [10:0] a, input logic [7:0] e);
    @(posedge pclk);
    usr_addr <= a;
    usr_raddr <= a;
    repeat (3) @(posedge pclk);
    #1 chk({24'h0, usr_dout}, {24'h0, e});
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #400us;
    n_fail++;
    $display("[ERR] %0t watchdog expired", $time);
    final_report();
  end
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    #1 chk({30'h0, usr_full, usr_empty}, 32'h1);
    rd(`CERB_OFF_CFG, 32'h0, 1'b0);
    rd(`CERB_OFF_STAT, 32'h2, 1'b0);
    rd(12'h010, 32'h0, 1'b1);
    done("reset");
    for (int m = 0; m < 3; m += 2) begin
      apb(1'b1, `CERB_OFF_CFG, 32'h200 | (m << 2));
      uwr(7 + m, 8'ha5 + m);
      ucheck(7 + m, 8'ha5 + m);
      usr_din <= 8'h3c;
      p_u.edge_in();
      ucheck(7 + m, 8'ha5 + m);
    end
    done("ram");
    apb(1'b1, `CERB_OFF_CFG, 32'h280);
    @(posedge pclk);
    usr_addr <= 11'h009;
    usr_din <= 8'h5a;
    glb_we <= 1'b1;
    p_u.edge_in();
    glb_we <= 1'b0;
    ucheck(9, 8'h5a);
    done("global write");
    apb(1'b1, `CERB_OFF_LOAD, 32'h03c3);
    apb(1'b1, `CERB_OFF_CFG, 32'h204);
    ucheck(3, 8'hc3);
    uwr(3, 8'h00);
    ucheck(3, 8'hc3);
    done("rom");
    apb(1'b1, `CERB_OFF_LOAD, 32'h0096);
    for (int s = 1; s < 4; s++) begin
      apb(1'b1, `CERB_OFF_CFG, s);
      for (int k = 0; k < (1 << s); k++)
        ucheck(k, (8'h96 >> (k * (8 >> s))) & ((1 << (8 >> s)) - 1));
    end
    done("shapes");
    apb(1'b1, `CERB_OFF_CFG, 32'h820);
    ucheck(7, 8'h01);
    p_u.edge_out();
    #1 chk({24'h0, usr_dout}, 32'ha5);
    ucheck(3, 8'ha5);
    p_u.edge_out();
    #1 chk({24'h0, usr_dout}, 32'hc3);
    rd(`CERB_OFF_DOUT, 32'hc3, 1'b0);
    done("output register");
    apb(1'b1, `CERB_OFF_CFG, 32'ha0c);
    uwr(0, 8'h11);
    #1 chk({31'h0, usr_empty}, 32'h0);
    @(posedge pclk);
    usr_re <= 1'b1;
    p_u.edge_out();
    usr_re <= 1'b0;
    #1 chk({23'h0, usr_empty, usr_dout}, 32'h111);
    done("fifo");
    apb(1'b1, `CERB_OFF_CFG, 32'h100);
    pin_wr(11'h020, 8'h77, 1'b1);
    ucheck(11'h020, 8'h77);
    pin_wr(11'h020, 8'h33, 1'b0);
    ucheck(11'h020, 8'h77);
    done("pin clock");
    apb(1'b1, `CERB_OFF_CFG, 32'h250);
    uwr(7, 8'h5c);
    ucheck(7, 8'ha5);
    usr_din <= 8'h00;
    p_u.edge_in();
    ucheck(7, 8'h5c);
    done("input registers");
    apb(1'b1, `CERB_OFF_CFG, 32'h1000);
    rd(`CERB_OFF_STAT, 32'h3, 1'b0);
    apb(1'b1, `CERB_OFF_CFG, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    rd(`CERB_OFF_CFG, 32'h1000, 1'b0);
    done("lock");
    final_report();
  end
endmodule
